// File: supply_supervisor_pkg.sv
package supply_supervisor_pkg;
    // Power mode encoding from the power controller
    localparam logic [2:0] PMODE_RUN = 3'h0;
    localparam logic [2:0] PMODE_SLEEP = 3'h1;
    localparam logic [2:0] PMODE_LP_RUN = 3'h2;
    localparam logic [2:0] PMODE_LP_SLEEP = 3'h3;
    localparam logic [2:0] PMODE_STOP = 3'h4;
    localparam logic [2:0] PMODE_STANDBY = 3'h5;
    // Regulator mode encoding
    localparam logic [1:0] REG_MAIN = 2'h0;
    localparam logic [1:0] REG_LOW_POWER = 2'h1;
    localparam logic [1:0] REG_POWER_DOWN = 2'h2;
    // Threshold selections
    localparam int BROWNOUT_LEVELS = 5;
    localparam int DETECTOR_LEVELS = 7;
    localparam logic [2:0] BROWNOUT_SEL_RESET = 3'h0;
    localparam logic [2:0] DETECTOR_SEL_MAX = 3'h6;
    // Start-up delays in microseconds and the clock rate
    localparam int CLK_KHZ = 20000;
    localparam int STARTUP_BOR_US = 3300;
    localparam int STARTUP_NOBOR_US = 1000;
    localparam int STARTUP_BOR_CYCLES = STARTUP_BOR_US * CLK_KHZ / 1000;
    localparam int STARTUP_NOBOR_CYCLES = STARTUP_NOBOR_US * CLK_KHZ / 1000;
    localparam int STARTUP_CNT_W = 17;
    // Option byte load length in cycles
    localparam logic [3:0] OPT_LOAD_CYCLES = 4'h8;
endpackage : supply_supervisor_pkg

// File: level_sync.sv
`timescale 1ns/1ns
`default_nettype none
module level_sync (
    input wire logic clk_sys_i, // System clock
    input wire logic rst_n_i, // Active low reset
    input wire logic async_i, // Asynchronous level
    output logic sync_o // Synchronised level
);
    logic meta_reg;
    // Two stage synchroniser; the first stage feeds only the second
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule : level_sync
`default_nettype wire

// File: regulator_mode_sel.sv
`timescale 1ns/1ns
`default_nettype none
module regulator_mode_sel (
    input wire logic clk_sys_i, // System clock
    input wire logic rst_n_i, // Active low reset
    input wire logic [2:0] power_mode_i, // Device power mode
    input wire logic vref_auto_off_i, // Reference off in Stop option
    output logic [1:0] regulator_mode_o, // Regulator mode
    output logic regulator_hiz_o, // Regulator output high impedance
    output logic vref_enable_o, // Internal reference enable
    output logic core_retain_lost_o // Core registers and RAM lost
);
    // Regulator mode follows power mode, registered to avoid glitches
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            regulator_mode_o <= supply_supervisor_pkg::REG_MAIN;
            regulator_hiz_o <= 1'b0;
            core_retain_lost_o <= 1'b0;
        end else begin
            case (power_mode_i)
                supply_supervisor_pkg::PMODE_RUN,
                supply_supervisor_pkg::PMODE_SLEEP: begin
                    regulator_mode_o <= supply_supervisor_pkg::REG_MAIN;
                    regulator_hiz_o <= 1'b0;
                    core_retain_lost_o <= 1'b0;
                end
                supply_supervisor_pkg::PMODE_STANDBY: begin
                    regulator_mode_o <= supply_supervisor_pkg::REG_POWER_DOWN;
                    regulator_hiz_o <= 1'b1;
                    core_retain_lost_o <= 1'b1;
                end
                default: begin
                    regulator_mode_o <= supply_supervisor_pkg::REG_LOW_POWER;
                    regulator_hiz_o <= 1'b0;
                    core_retain_lost_o <= 1'b0;
                end
            endcase
        end
    end

    // Reference may be dropped in Stop to save current
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vref_enable_o <= 1'b1;
        end else begin
            vref_enable_o <= !(vref_auto_off_i
                && power_mode_i == supply_supervisor_pkg::PMODE_STOP);
        end
    end
endmodule : regulator_mode_sel
`default_nettype wire

// File: supply_supervisor_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module supply_supervisor_sequencer (
    input wire logic clk_sys_i, // Always-on clock
    input wire logic resetn_i, // Power-on reset, active low
    input wire logic por_ok_i, // Supply above power-on/down level
    input wire logic bor_start_ok_i, // Supply above 1.8 V start level
    input wire logic [4:0] bor_cmp_i, // Supply above each brownout level
    input wire logic bor_active_at_por_i, // Brownout version strap
    input wire logic opt_valid_i, // Option bytes read back
    input wire logic opt_bor_disable_i, // Option: brownout off permanently
    input wire logic [2:0] opt_bor_level_i, // Option: brownout level select
    input wire logic detector_enable_i, // Software enables detector
    input wire logic [2:0] detector_threshold_i, // Software detector level
    input wire logic detector_cmp_i, // Detector comparator, high when above
    input wire logic detector_irq_fall_en_i, // Interrupt on falling crossing
    input wire logic detector_irq_rise_en_i, // Interrupt on rising crossing
    input wire logic detector_flag_clr_i, // Clear detector flag pulse
    input wire logic [2:0] power_mode_i, // Device power mode
    input wire logic vref_auto_off_i, // Reference off in Stop option
    output logic chip_reset_n_o, // Internal reset, active low
    output logic opt_load_o, // Option byte load in progress
    output logic brownout_enabled_o, // Brownout detection in force
    output logic [2:0] brownout_level_o, // Active brownout level
    output logic detector_on_o, // Detector comparator powered
    output logic [2:0] detector_threshold_o, // Level sent to detector
    output logic detector_flag_o, // Sticky detector event
    output logic detector_irq_o, // Detector interrupt
    output logic [1:0] regulator_mode_o, // Regulator mode
    output logic regulator_hiz_o, // Regulator high impedance
    output logic vref_enable_o, // Internal reference enable
    output logic core_retain_lost_o // Core state lost in Standby
);
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_LOAD = 4'h2,
        ST_DELAY = 4'h4,
        ST_RUN = 4'h8
    } seq_state_t;

    logic rst_meta_reg;
    logic rst_n;
    seq_state_t state_reg;
    logic [3:0] load_cnt_reg;
    logic [16:0] delay_cnt_reg;
    logic [16:0] delay_target;
    logic bor_en_reg;
    logic [2:0] bor_level_reg;
    logic bor_selected_ok;
    logic supply_ok;
    logic start_ok;
    logic det_sync;
    logic det_prev_reg;
    logic det_event;

    // Reset release through two flops
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // Out-of-range selections clamp to the top brownout level
    assign bor_selected_ok = (bor_level_reg < 3'(supply_supervisor_pkg::BROWNOUT_LEVELS))
        ? bor_cmp_i[bor_level_reg] : bor_cmp_i[4];

    // Brownout version needs 1.8 V; without it the power-on level suffices
    assign start_ok = bor_active_at_por_i ? (por_ok_i && bor_start_ok_i) : por_ok_i;
    assign supply_ok = por_ok_i && (!bor_en_reg || bor_selected_ok);

    // Delay length depends on whether brownout is enabled
    assign delay_target = bor_en_reg
        ? 17'(supply_supervisor_pkg::STARTUP_BOR_CYCLES - 1)
        : 17'(supply_supervisor_pkg::STARTUP_NOBOR_CYCLES - 1);

    // Power-up sequencer; a supply drop sends it back to reset, though loading watches only the power-on level
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_OFF;
            load_cnt_reg <= 4'h0;
            delay_cnt_reg <= 17'h00000;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    load_cnt_reg <= 4'h0;
                    if (start_ok) begin
                        state_reg <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (!por_ok_i) begin
                        state_reg <= ST_OFF;
                    end else if (opt_valid_i
                        && load_cnt_reg >= supply_supervisor_pkg::OPT_LOAD_CYCLES) begin
                        state_reg <= ST_DELAY;
                        delay_cnt_reg <= 17'h00000;
                    end else if (load_cnt_reg < supply_supervisor_pkg::OPT_LOAD_CYCLES) begin
                        load_cnt_reg <= load_cnt_reg + 4'h1;
                    end
                end
                ST_DELAY: begin
                    if (!supply_ok) begin
                        state_reg <= ST_OFF;
                    end else if (delay_cnt_reg >= delay_target) begin
                        state_reg <= ST_RUN;
                    end else begin
                        delay_cnt_reg <= delay_cnt_reg + 17'h00001;
                    end
                end
                ST_RUN: begin
                    if (!supply_ok) begin
                        state_reg <= ST_OFF;
                    end
                end
                default: begin
                    state_reg <= ST_OFF;
                end
            endcase
        end
    end

    // Brownout setup: strap default, then option bytes confirm or change it
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            bor_en_reg <= 1'b0;
            bor_level_reg <= supply_supervisor_pkg::BROWNOUT_SEL_RESET;
        end else if (state_reg == ST_OFF) begin
            bor_en_reg <= bor_active_at_por_i;
            bor_level_reg <= supply_supervisor_pkg::BROWNOUT_SEL_RESET;
        end else if (state_reg == ST_LOAD && opt_valid_i) begin
            bor_en_reg <= !opt_bor_disable_i;
            bor_level_reg <= opt_bor_level_i;
        end
    end

    // Internal reset held until sequencer reaches run
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            chip_reset_n_o <= 1'b0;
            opt_load_o <= 1'b0;
            brownout_enabled_o <= 1'b0;
            brownout_level_o <= supply_supervisor_pkg::BROWNOUT_SEL_RESET;
        end else begin
            chip_reset_n_o <= (state_reg == ST_RUN) && supply_ok;
            opt_load_o <= (state_reg == ST_LOAD);
            brownout_enabled_o <= bor_en_reg;
            brownout_level_o <= bor_level_reg;
        end
    end

    // Detector config; level clamped to the seven legal values
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            detector_on_o <= 1'b0;
            detector_threshold_o <= 3'h0;
        end else begin
            detector_on_o <= detector_enable_i && chip_reset_n_o;
            detector_threshold_o <= (detector_threshold_i > supply_supervisor_pkg::DETECTOR_SEL_MAX)
                ? supply_supervisor_pkg::DETECTOR_SEL_MAX : detector_threshold_i;
        end
    end

    // Comparator is asynchronous to our clock
    level_sync u_det_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n),
        .async_i(detector_cmp_i),
        .sync_o(det_sync)
    );

    // Edge history is primed while off so enabling does not fake a crossing
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            det_prev_reg <= 1'b0;
        end else begin
            det_prev_reg <= det_sync;
        end
    end

    assign det_event = detector_on_o && ((detector_irq_fall_en_i && det_prev_reg && !det_sync)
        || (detector_irq_rise_en_i && !det_prev_reg && det_sync));

    // Sticky flag; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            detector_flag_o <= 1'b0;
        end else if (det_event) begin
            detector_flag_o <= 1'b1;
        end else if (detector_flag_clr_i) begin
            detector_flag_o <= 1'b0;
        end
    end

    assign detector_irq_o = detector_flag_o;

    regulator_mode_sel u_reg_sel (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n),
        .power_mode_i(power_mode_i),
        .vref_auto_off_i(vref_auto_off_i),
        .regulator_mode_o(regulator_mode_o),
        .regulator_hiz_o(regulator_hiz_o),
        .vref_enable_o(vref_enable_o),
        .core_retain_lost_o(core_retain_lost_o)
    );
endmodule : supply_supervisor_sequencer
`default_nettype wire

// File: supply_supervisor_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module supply_supervisor_asserts (
    input wire logic clk_sys_i, // Clock
    input wire logic resetn_i, // Reset
    input wire logic por_ok_i, // Supply ok
    input wire logic bor_start_ok_i, // Start level
    input wire logic bor_active_at_por_i, // Strap
    input wire logic detector_enable_i, // Detector enable
    input wire logic [2:0] detector_threshold_i, // Level in
    input wire logic detector_cmp_i, // Comparator
    input wire logic detector_irq_fall_en_i, // Fall enable
    input wire logic detector_flag_clr_i, // Clear
    input wire logic [2:0] power_mode_i, // Power mode
    input wire logic vref_auto_off_i, // Reference option
    input wire logic chip_reset_n_o, // Chip reset
    input wire logic opt_load_o, // Loading
    input wire logic brownout_enabled_o, // Brownout on
    input wire logic detector_on_o, // Detector on
    input wire logic [2:0] detector_threshold_o, // Level out
    input wire logic detector_flag_o, // Flag
    input wire logic [1:0] regulator_mode_o, // Regulator
    input wire logic regulator_hiz_o, // High impedance
    input wire logic vref_enable_o, // Reference on
    input wire logic core_retain_lost_o // State lost
);
    logic [1:0] rel_q;
    logic [16:0] run_q;
    // Checks wait for the reset synchroniser, outputs lag the port by three edges
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rel_q <= 2'h0;
        end else if (rel_q != 2'h3) begin
            rel_q <= rel_q + 2'h1;
        end
    end
    // Cycles since option loading ended, saturating so it never wraps
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_q <= 17'h0;
        end else if (opt_load_o) begin
            run_q <= 17'h0;
        end else if (run_q != 17'h1FFFF) begin
            run_q <= run_q + 17'h1;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i || rel_q != 2'h3);
    sequence fall_held;
        $fell(detector_cmp_i)
            ##0 (!detector_cmp_i && detector_on_o && detector_irq_fall_en_i) [*5];
    endsequence
    // A load that ends with the supply still up must have run its full length;
    // a supply drop may cut it short, so those ends are not judged here
    sequence load_done;
        $fell(opt_load_o) && $past(por_ok_i, 2);
    endsequence
    chk_reset_supply: assert property (
        !por_ok_i [*2] |-> !chip_reset_n_o)
        else $error("reset released with supply low");
    chk_load_hold: assert property (
        load_done |-> $past(opt_load_o, 9) && !$past(chip_reset_n_o))
        else $error("option load too short");
    chk_start_level: assert property (
        $rose(opt_load_o) && $past(bor_active_at_por_i, 2) |-> $past(bor_start_ok_i, 2))
        else $error("load began below start level");
    chk_startup_delay: assert property (
        $rose(chip_reset_n_o) |-> run_q >= (brownout_enabled_o ? 17'h101CE : 17'h4E1E))
        else $error("start-up delay too short");
    chk_regulator_lp: assert property (
        power_mode_i inside {3'h2, 3'h3, 3'h4}
            |=> regulator_mode_o == supply_supervisor_pkg::REG_LOW_POWER)
        else $error("regulator not low power");
    chk_standby_hiz: assert property (
        power_mode_i == 3'h5 |=> regulator_hiz_o && core_retain_lost_o)
        else $error("standby regulator not off");
    chk_vref_stop: assert property (
        power_mode_i == 3'h4 && vref_auto_off_i |=> !vref_enable_o)
        else $error("reference kept on in stop");
    chk_detector_off: assert property (
        !detector_enable_i || !chip_reset_n_o |=> !detector_on_o)
        else $error("detector on while disabled");
    chk_flag_sticky: assert property (
        detector_flag_o && !detector_flag_clr_i |=> detector_flag_o)
        else $error("flag lost without clear");
    chk_fall_flag: assert property (
        fall_held |-> ##[0:1] detector_flag_o)
        else $error("falling crossing not flagged");
    chk_level_clamp: assert property (
        1'b1 |=> detector_threshold_o == ($past(detector_threshold_i) == 3'h7
            ? supply_supervisor_pkg::DETECTOR_SEL_MAX : $past(detector_threshold_i)))
        else $error("detector level wrong");
endmodule : supply_supervisor_asserts
bind supply_supervisor_sequencer supply_supervisor_asserts supply_supervisor_asserts_i (.*);
`default_nettype wire

// File: supply_supervisor_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module supply_supervisor_sequencer_tb;
    logic clk_sys_i = 1'b0, resetn_i = 1'b0, por_ok_i = 1'b0, bor_start_ok_i = 1'b0;
    logic bor_active_at_por_i = 1'b1, opt_valid_i = 1'b1, opt_bor_disable_i = 1'b0;
    logic [4:0] bor_cmp_i = 5'h1F;
    logic [2:0] opt_bor_level_i = 3'h2, detector_threshold_i = 3'h0, power_mode_i = 3'h0;
    logic detector_enable_i = 1'b0, detector_cmp_i = 1'b1, detector_irq_fall_en_i = 1'b1;
    logic detector_irq_rise_en_i = 1'b0, detector_flag_clr_i = 1'b0, vref_auto_off_i = 1'b1;
    logic chip_reset_n_o, opt_load_o, brownout_enabled_o, detector_on_o, detector_flag_o;
    logic detector_irq_o, regulator_hiz_o, vref_enable_o, core_retain_lost_o;
    logic [2:0] brownout_level_o, detector_threshold_o;
    logic [1:0] regulator_mode_o;
    int n_mismatch = 0, n_checks = 0;
    supply_supervisor_sequencer supply_supervisor_sequencer_i (.*);
    // Free-running 20 MHz clock
    always #25 clk_sys_i = ~clk_sys_i;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cyc
    task automatic chk(input logic [2:0] got, input logic [2:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : chk
    task automatic complete_run;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    // Bounded waits keep a stuck sequencer from hanging the run
    task automatic power_up(input int dly);
        int n;
        n = 0;
        while (opt_load_o !== 1'b1 && n < 100) begin cyc(1); n++; end
        n = 0;
        while (opt_load_o === 1'b1 && n < 100) begin cyc(1); n++; end
        chk(n >= 9, 1'b1, "load length");
        n = 0;
        while (chip_reset_n_o !== 1'b1 && n < 70000) begin cyc(1); n++; end
        chk(n >= dly - 2 && n <= dly + 4, 1'b1, "start-up delay");
    endtask : power_up
    // Main sequence
    initial begin
        cyc(16);
        chk({chip_reset_n_o, regulator_mode_o}, 3'h0, "reset outputs");
        chk(vref_enable_o, 1'b1, "reset reference");
        // Release on a rising edge like every other stimulus change
        @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        por_ok_i <= 1'b1;
        cyc(50);
        chk(opt_load_o, 1'b0, "load below start level");
        @(posedge clk_sys_i);
        bor_start_ok_i <= 1'b1;
        power_up(66000);
        chk(brownout_enabled_o, 1'b1, "brownout enabled");
        chk(brownout_level_o, 3'h2, "brownout level");
        for (int m = 0; m < 6; m++) begin
            @(posedge clk_sys_i);
            power_mode_i <= 3'(m);
            cyc(2);
            chk(regulator_mode_o, (m == 5) ? 3'h2 : (m >= 2) ? 3'h1 : 3'h0, "regulator");
            chk({regulator_hiz_o, core_retain_lost_o}, (m == 5) ? 3'h3 : 3'h0, "standby");
            chk(vref_enable_o, m != 4, "reference");
        end
        @(posedge clk_sys_i);
        power_mode_i <= 3'h4;
        vref_auto_off_i <= 1'b0;
        cyc(2);
        chk(vref_enable_o, 1'b1, "reference kept");
        chk(detector_on_o, 1'b0, "detector default off");
        for (int t = 0; t < 8; t++) begin
            @(posedge clk_sys_i);
            detector_threshold_i <= 3'(t);
            cyc(2);
            chk(detector_threshold_o, (t == 7) ? 3'h6 : 3'(t), "detector level");
        end
        @(posedge clk_sys_i);
        power_mode_i <= 3'h0;
        detector_enable_i <= 1'b1;
        cyc(3);
        chk(detector_on_o, 1'b1, "detector on");
        // Falling crossing flags once; rising is ignored while its enable is off
        @(posedge clk_sys_i);
        detector_cmp_i <= 1'b0;
        cyc(6);
        chk({detector_flag_o, detector_irq_o}, 3'h3, "fall flag");
        @(posedge clk_sys_i);
        detector_flag_clr_i <= 1'b1;
        @(posedge clk_sys_i);
        detector_flag_clr_i <= 1'b0;
        cyc(3);
        chk(detector_flag_o, 1'b0, "flag cleared once");
        @(posedge clk_sys_i);
        detector_cmp_i <= 1'b1;
        cyc(6);
        chk(detector_flag_o, 1'b0, "rise masked");
        @(posedge clk_sys_i);
        detector_irq_rise_en_i <= 1'b1;
        detector_irq_fall_en_i <= 1'b0;
        detector_cmp_i <= 1'b0;
        cyc(6);
        chk(detector_flag_o, 1'b0, "fall masked");
        @(posedge clk_sys_i);
        detector_cmp_i <= 1'b1;
        cyc(6);
        chk(detector_irq_o, 1'b1, "rise flag");
        // Supply falls under the selected brownout level
        @(posedge clk_sys_i);
        bor_cmp_i <= 5'h1B;
        cyc(3);
        chk(chip_reset_n_o, 1'b0, "brownout reset");
        chk(detector_on_o, 1'b0, "detector off in reset");
        @(posedge clk_sys_i);
        por_ok_i <= 1'b0;
        cyc(4);
        @(posedge clk_sys_i);
        bor_active_at_por_i <= 1'b0;
        opt_bor_disable_i <= 1'b1;
        bor_start_ok_i <= 1'b0;
        bor_cmp_i <= 5'h00;
        por_ok_i <= 1'b1;
        power_up(20000);
        chk(brownout_enabled_o, 1'b0, "brownout disabled");
        @(posedge clk_sys_i);
        por_ok_i <= 1'b0;
        cyc(3);
        chk(chip_reset_n_o, 1'b0, "power-down reset");
        complete_run();
    end
    // Watchdog, a little beyond the expected length of the run
    initial begin
        #5000000;
        n_mismatch++;
        complete_run();
    end
endmodule : supply_supervisor_sequencer_tb
`default_nettype wire
